//--- rtl/bpw_pkg.sv
/*
  Package for the board power-state and wake controller: states, timing
  counts, wake-source bundle and setting bundle.
  Assumes a single 200 MHz clock domain.
*/
package bpw_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned LONG_PRESS_S = 7;
  localparam longint unsigned LONG_PRESS_CYC = longint'(LONG_PRESS_S) * CLK_HZ;
  localparam int unsigned PRESS_CNT_W = 34;
  localparam int unsigned IDLE_CNT_W = 40;
  localparam logic PM_EN_RST = 1'b1;

  typedef enum logic [4:0] {
    BPW_S0 = 5'h01,
    BPW_STBY = 5'h02,
    BPW_S1 = 5'h04,
    BPW_S3 = 5'h08,
    BPW_S5 = 5'h10
  } bpw_state_t;

  typedef struct packed {
    logic rtc_alarm;
    logic net_wake;
    logic pme_slot2;
    logic pme_other;
    logic ring_port_a;
    logic ring_riser;
    logic usb;
    logic kbd;
    logic mouse;
  } bpw_wake_t;

  typedef struct packed {
    logic pm_enable;
    logic net_s5_power_on;
    logic pme_s5_power_on;
    logic sleep_to_s3;
  } bpw_cfg_t;

endpackage

//--- rtl/bpw_press_timer.sv
/*
  Power-switch press timer: measures the length of each press.
  Assumes the switch input is already synchronised to MCLK.
*/
`timescale 1ns/1ps
module bpw_press_timer
  import bpw_pkg::*;
#(
  parameter longint unsigned LONG_CYC = LONG_PRESS_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sw,
  output logic short_press,
  output logic long_press
);

  logic sw_q, sw_d;
  logic [PRESS_CNT_W-1:0] cnt_q, cnt_d;
  logic long_done_q, long_done_d;
  logic short_q, short_d;
  logic long_q, long_d;

  always_comb begin
    sw_d = sw;
    cnt_d = cnt_q;
    long_done_d = long_done_q;
    short_d = 1'b0;
    long_d = 1'b0;
    if (sw && !sw_q) begin
      cnt_d = PRESS_CNT_W'(1);
      long_done_d = 1'b0;
    end else if (sw) begin
      if (!long_done_q && cnt_q >= PRESS_CNT_W'(LONG_CYC - 1)) begin
        // Exactly seven seconds already counts as long
        long_d = 1'b1;
        long_done_d = 1'b1;
      end else if (!long_done_q) begin
        cnt_d = cnt_q + PRESS_CNT_W'(1);
      end
    end else if (sw_q && !long_done_q) begin
      short_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sw_q <= 1'b0;
      cnt_q <= '0;
      long_done_q <= 1'b0;
      short_q <= 1'b0;
      long_q <= 1'b0;
    end else begin
      sw_q <= sw_d;
      cnt_q <= cnt_d;
      long_done_q <= long_done_d;
      short_q <= short_d;
      long_q <= long_d;
    end
  end

  assign short_press = short_q;
  assign long_press = long_q;

endmodule

//--- rtl/bpw_ctrl.sv
/*
  Board power-state and wake controller: working, standby, S1, S3, S5.
  Decodes switch presses, qualifies wake sources per state, and handles
  standby entry and exit. Settings arrive as plain ports from firmware;
  switch and wake inputs are asynchronous pins.
*/
`timescale 1ns/1ps
module bpw_ctrl
  import bpw_pkg::*;
#(
  parameter longint unsigned LONG_CYC = LONG_PRESS_CYC
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic PWR_SW,
  input wire bpw_wake_t WAKE,
  input wire logic IRQ_IN,
  input wire bpw_cfg_t CFG,
  input wire logic CFG_PM_WRITE,
  input wire logic ACPI_OS,
  input wire logic [IDLE_CNT_W-1:0] IDLE_TIMEOUT,
  input wire logic OS_STANDBY_REQ,
  input wire logic OS_SLEEP_REQ,
  input wire logic OS_OFF_REQ,
  output bpw_state_t STATE,
  output logic MAIN_PWR_ON,
  output logic MONITOR_ON,
  output logic CPU_RUN,
  output logic CONTEXT_VALID,
  output logic COLD_BOOT,
  output logic WAKE_LOGIC_ONLY,
  output logic IRQ_SERVICE,
  output logic PM_ENABLED,
  output logic ACPI_MODE,
  output logic WAKE_EVENT
);

  // Pins cross into MCLK through two flops before any use
  localparam int unsigned NSYNC = 11;
  logic [NSYNC-1:0] sync1_q, sync2_q, sync_in;
  assign sync_in = {PWR_SW, WAKE, IRQ_IN};

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sync_in;
      sync2_q <= sync1_q;
    end
  end

  logic sw_s, irq_s;
  bpw_wake_t wk;
  assign sw_s = sync2_q[NSYNC-1];
  assign wk = bpw_wake_t'(sync2_q[NSYNC-2:1]);
  assign irq_s = sync2_q[0];

  logic short_press, long_press;

  bpw_press_timer #(
    .LONG_CYC(LONG_CYC)
  ) u_timer (
    .clk(MCLK),
    .rst(RESET),
    .sw(sw_s),
    .short_press(short_press),
    .long_press(long_press)
  );

  // Power management enable, set by default and written by firmware
  logic pm_en_q, pm_en_d;
  logic acpi_q, acpi_d;

  always_comb begin
    pm_en_d = pm_en_q;
    if (CFG_PM_WRITE) begin
      pm_en_d = CFG.pm_enable;
    end
    acpi_d = ACPI_OS;
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      pm_en_q <= PM_EN_RST;
      acpi_q <= 1'b0;
    end else begin
      pm_en_q <= pm_en_d;
      acpi_q <= acpi_d;
    end
  end

  // Wake qualification per sleep depth
  logic wake_light, wake_s5, input_act;
  always_comb begin
    // Riser modem ring is deliberately left out of every term
    wake_light = wk.rtc_alarm | wk.net_wake | wk.pme_slot2 | wk.pme_other
               | wk.ring_port_a | wk.usb | wk.kbd;
    // Only slot 2 PME counts in S5, and only when set to power-on
    wake_s5 = wk.rtc_alarm
            | (wk.net_wake & CFG.net_s5_power_on)
            | (wk.pme_slot2 & CFG.pme_s5_power_on);
    input_act = wk.kbd | wk.mouse;
  end

  // Inactivity counter for standby entry
  logic [IDLE_CNT_W-1:0] idle_q, idle_d;
  logic idle_exp;

  bpw_state_t st_q, st_d;
  logic wake_ev_q, wake_ev_d;

  always_comb begin
    idle_d = idle_q;
    idle_exp = 1'b0;
    if (st_q != BPW_S0 || input_act || IDLE_TIMEOUT == '0) begin
      idle_d = '0;
    end else if (idle_q >= IDLE_TIMEOUT - IDLE_CNT_W'(1)) begin
      idle_exp = 1'b1;
      idle_d = '0;
    end else begin
      idle_d = idle_q + IDLE_CNT_W'(1);
    end
  end

  always_comb begin
    st_d = st_q;
    wake_ev_d = 1'b0;
    unique case (st_q)
      BPW_S0: begin
        if (long_press || OS_OFF_REQ) begin
          st_d = BPW_S5;
        end else if (short_press || OS_SLEEP_REQ) begin
          st_d = CFG.sleep_to_s3 ? BPW_S3 : BPW_S1;
        end else if (pm_en_q && !acpi_q && (OS_STANDBY_REQ || idle_exp)) begin
          st_d = BPW_STBY;
        end
      end
      BPW_STBY: begin
        if (long_press) begin
          st_d = BPW_S5;
        end else if (input_act || short_press || !pm_en_q) begin
          st_d = BPW_S0;
          wake_ev_d = input_act;
        end
      end
      BPW_S1, BPW_S3: begin
        if (long_press) begin
          st_d = BPW_S5;
        end else if (short_press || wake_light) begin
          st_d = BPW_S0;
          wake_ev_d = 1'b1;
        end
      end
      BPW_S5: begin
        if (short_press || wake_s5) begin
          st_d = BPW_S0;
          wake_ev_d = 1'b1;
        end
      end
    endcase
  end

  // Output images come from the next state, so they change on the same edge as STATE
  logic main_q, main_d, mon_q, mon_d, cpu_q, cpu_d, ctx_q, ctx_d;
  logic cold_q, cold_d, wlo_q, wlo_d, irqs_q, irqs_d;

  always_comb begin
    main_d = (st_d == BPW_S0) || (st_d == BPW_STBY) || (st_d == BPW_S1);
    mon_d = (st_d == BPW_S0);
    cpu_d = (st_d == BPW_S0) || (st_d == BPW_STBY);
    ctx_d = (st_d != BPW_S5);
    // Cold boot flag stays up through the first working cycle after S5
    cold_d = (st_d == BPW_S5) || (cold_q && st_d == BPW_S0 && st_q != BPW_S0);
    wlo_d = (st_d == BPW_S5) || (st_d == BPW_S3);
    // Standby keeps the interrupt path alive; the sleep states and S5 drop it
    irqs_d = irq_s && ((st_d == BPW_S0) || (st_d == BPW_STBY));
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      st_q <= BPW_S5;
      idle_q <= '0;
      wake_ev_q <= 1'b0;
      main_q <= 1'b0;
      mon_q <= 1'b0;
      cpu_q <= 1'b0;
      ctx_q <= 1'b0;
      cold_q <= 1'b1;
      wlo_q <= 1'b1;
      irqs_q <= 1'b0;
    end else begin
      st_q <= st_d;
      idle_q <= idle_d;
      wake_ev_q <= wake_ev_d;
      main_q <= main_d;
      mon_q <= mon_d;
      cpu_q <= cpu_d;
      ctx_q <= ctx_d;
      cold_q <= cold_d;
      wlo_q <= wlo_d;
      irqs_q <= irqs_d;
    end
  end

  assign STATE = st_q;
  assign MAIN_PWR_ON = main_q;
  assign MONITOR_ON = mon_q;
  assign CPU_RUN = cpu_q;
  assign CONTEXT_VALID = ctx_q;
  assign COLD_BOOT = cold_q;
  assign WAKE_LOGIC_ONLY = wlo_q;
  assign IRQ_SERVICE = irqs_q;
  assign PM_ENABLED = pm_en_q;
  assign ACPI_MODE = acpi_q;
  assign WAKE_EVENT = wake_ev_q;

endmodule

//--- tb/bpw_chk.sv
/*
  Port checker for bpw_ctrl.
  Assumes one MCLK domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module bpw_chk
  import bpw_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire bpw_wake_t WAKE,
  input wire logic IRQ_IN,
  input wire bpw_cfg_t CFG,
  input wire logic CFG_PM_WRITE,
  input wire logic ACPI_OS,
  input wire bpw_state_t STATE,
  input wire logic MONITOR_ON,
  input wire logic CONTEXT_VALID,
  input wire logic COLD_BOOT,
  input wire logic WAKE_LOGIC_ONLY,
  input wire logic IRQ_SERVICE,
  input wire logic PM_ENABLED,
  input wire logic ACPI_MODE,
  input wire logic WAKE_EVENT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  a_s5_no_ctx: assert property (STATE == BPW_S5 |-> !CONTEXT_VALID && WAKE_LOGIC_ONLY)
    else $error("S5 keeps context");
  a_cold_entry: assert property ($past(STATE) == BPW_S5 && STATE == BPW_S0 |-> COLD_BOOT)
    else $error("no cold boot from S5");
  a_monitor_s0: assert property (MONITOR_ON == (STATE == BPW_S0))
    else $error("monitor power wrong");
  a_wake_pulse: assert property (WAKE_EVENT |->
    (STATE == BPW_S0 && $past(STATE) != BPW_S0) ##1 !WAKE_EVENT)
    else $error("wake pulse wrong");
  a_mouse_exit: assert property (STATE == BPW_STBY && $past(WAKE.mouse, 2) |->
    ##[1:2] STATE == BPW_S0)
    else $error("standby not left");
  a_irq_stby: assert property (STATE == BPW_STBY && $past(STATE) == BPW_STBY &&
    $past(IRQ_IN, 3) |-> IRQ_SERVICE)
    else $error("interrupt not serviced");
  a_pm_write: assert property (CFG_PM_WRITE |=> PM_ENABLED == $past(CFG.pm_enable))
    else $error("pm enable not loaded");
  a_acpi_follow: assert property (!$past(RESET) |-> ACPI_MODE == $past(ACPI_OS))
    else $error("acpi mode wrong");
  a_stby_entry: assert property (STATE == BPW_STBY && $past(STATE) == BPW_S0 |->
    $past(PM_ENABLED) && !$past(ACPI_MODE))
    else $error("bad standby entry");
  c_wake: cover property (WAKE_EVENT);
  c_stby: cover property (STATE == BPW_STBY);
  c_long: cover property ($past(STATE) == BPW_S0 && STATE == BPW_S5);
endmodule
bind bpw_ctrl bpw_chk u_chk (.MCLK, .RESET, .WAKE, .IRQ_IN, .CFG, .CFG_PM_WRITE, .ACPI_OS,
  .STATE, .MONITOR_ON, .CONTEXT_VALID, .COLD_BOOT, .WAKE_LOGIC_ONLY, .IRQ_SERVICE,
  .PM_ENABLED, .ACPI_MODE, .WAKE_EVENT);

//--- tb/bpw_sw_model.sv
/*
  Front-panel power switch model.
  Assumes the caller times presses in whole MCLK cycles.
*/
`timescale 1ns/1ps
module bpw_sw_model (
  input wire logic clk,
  output logic sw
);
  initial sw = 1'b0;
  // Bounce-free contact: press length is exact, so boundaries are sharp
  task automatic press(input int n);
    @(negedge clk);
    sw = 1'b1;
    repeat (n) @(negedge clk);
    sw = 1'b0;
  endtask
endmodule

//--- tb/tb.sv
/*
  Self-checking bench for bpw_ctrl with a short long-press count.
  Assumes the switch model and the bound checker.
*/
`timescale 1ns/1ps
module tb;
  import bpw_pkg::*;
  localparam longint unsigned LC = 20;
  logic MCLK = 0, RESET = 1, IRQ_IN = 0, CFG_PM_WRITE = 0, ACPI_OS = 0, sw;
  logic [2:0] osr = '0;
  logic [IDLE_CNT_W-1:0] idle = '0;
  bpw_wake_t WAKE = '0;
  bpw_cfg_t CFG = 4'h8;
  bpw_state_t STATE;
  logic mon, ctx, cold, wlo, irqs, pm, acpi, wev, main, cpu;
  int errors = 0, checked = 0;
  bpw_sw_model swm (.clk(MCLK), .sw(sw));
  bpw_ctrl #(.LONG_CYC(LC)) uut (.MCLK(MCLK), .RESET(RESET), .PWR_SW(sw), .WAKE(WAKE),
    .IRQ_IN(IRQ_IN), .CFG(CFG), .CFG_PM_WRITE(CFG_PM_WRITE), .ACPI_OS(ACPI_OS),
    .IDLE_TIMEOUT(idle), .OS_STANDBY_REQ(osr[0]), .OS_SLEEP_REQ(osr[1]),
    .OS_OFF_REQ(osr[2]), .STATE(STATE), .MAIN_PWR_ON(main), .MONITOR_ON(mon), .CPU_RUN(cpu),
    .CONTEXT_VALID(ctx), .COLD_BOOT(cold), .WAKE_LOGIC_ONLY(wlo), .IRQ_SERVICE(irqs),
    .PM_ENABLED(pm), .ACPI_MODE(acpi), .WAKE_EVENT(wev));
  always #2.5 MCLK = ~MCLK;
  task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(negedge MCLK);
  endtask
  // Bounded wait, so a stuck state shows up as a mismatch
  task automatic go(input bpw_state_t s, input int n);
    for (int i = 0; i < n && STATE !== s; i++) @(negedge MCLK);
    chk("STATE", s, STATE);
  endtask
  task automatic wk(input int b);
    WAKE = bpw_wake_t'(9'h1 << b);
    hold(4);
    WAKE = '0;
    hold(1);
  endtask
  task automatic os(input logic [2:0] k);
    osr = k;
    hold(1);
    osr = '0;
    hold(3);
  endtask
  task automatic t_s5;
    int bl[7] = '{6, 5, 4, 3, 2, 1, 7};
    foreach (bl[i]) begin
      wk(bl[i]);
      chk("STATE", BPW_S5, STATE);
    end
    CFG.pme_s5_power_on = 1'b1;
    wk(5);
    chk("STATE", BPW_S5, STATE);
    wk(6);
    go(BPW_S0, 4);
    CFG.pme_s5_power_on = 1'b0;
    os(3'h4);
    go(BPW_S5, 3);
    CFG.net_s5_power_on = 1'b1;
    wk(7);
    go(BPW_S0, 4);
    chk("COLD", 0, cold);
  endtask
  task automatic t_sleep;
    int bl[7] = '{8, 7, 6, 5, 4, 2, 1};
    swm.press(3);
    go(BPW_S1, 10);
    chk("MAIN", 1, main);
    wk(3);
    chk("STATE", BPW_S1, STATE);
    foreach (bl[i]) begin
      if (i > 0) begin
        CFG.sleep_to_s3 = i[0];
        swm.press(3);
        go(i[0] ? BPW_S3 : BPW_S1, 10);
        chk("MAIN", i[0] ? 5'h0 : 5'h1, main);
        chk("CPU", 0, cpu);
      end
      wk(bl[i]);
      go(BPW_S0, 4);
    end
    CFG.sleep_to_s3 = 1'b0;
  endtask
  task automatic t_press;
    swm.press(LC - 1);
    go(BPW_S1, 10);
    swm.press(LC);
    go(BPW_S5, 10);
    chk("CTX", 0, ctx);
    swm.press(3);
    go(BPW_S0, 10);
    swm.press(LC);
    go(BPW_S5, 10);
    wk(8);
    go(BPW_S0, 4);
    os(3'h2);
    go(BPW_S1, 3);
    wk(0);
    chk("STATE", BPW_S1, STATE);
    wk(2);
    go(BPW_S0, 4);
  endtask
  task automatic t_stby;
    ACPI_OS = 1'b1;
    hold(2);
    chk("ACPI", 1, acpi);
    os(3'h1);
    chk("STATE", BPW_S0, STATE);
    ACPI_OS = 1'b0;
    hold(2);
    os(3'h1);
    go(BPW_STBY, 3);
    chk("CPU", 1, cpu);
    chk("MON", 0, mon);
    IRQ_IN = 1'b1;
    hold(5);
    chk("IRQ", 1, irqs);
    IRQ_IN = 1'b0;
    wk(0);
    go(BPW_S0, 4);
    chk("MON", 1, mon);
    idle = 40'ha;
    go(BPW_STBY, 30);
    idle = '0;
    wk(1);
    go(BPW_S0, 4);
    CFG.pm_enable = 1'b0;
    CFG_PM_WRITE = 1'b1;
    hold(1);
    CFG_PM_WRITE = 1'b0;
    hold(1);
    chk("PM", 0, pm);
    os(3'h1);
    chk("STATE", BPW_S0, STATE);
    os(3'h4);
    go(BPW_S5, 3);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    tally_and_finish;
  end
  initial begin
    hold(6);
    RESET = 1'b0;
    hold(3);
    chk("STATE", BPW_S5, STATE);
    chk("FLAGS", 5'h1c, {cold, wlo, pm, ctx, acpi});
    chk("OUTS", 5'h00, {main, cpu, mon, irqs, wev});
    t_s5();
    t_sleep();
    t_press();
    t_stby();
    tally_and_finish;
  end
endmodule
